// *** mac8_accumulator.v ***
// 8x8 multiplier-accumulator with 19-bit product register and preload
// assumes strobes and pin data arrive from outside the core_clk_i domain
`timescale 1ns/1ps
`include "mac8_defines.vh"
`default_nettype none

module mac8_accumulator (
  // clock and reset
  input  wire                   core_clk_i,
  input  wire                   rst_n_i,
  // operand strobes and data
  input  wire                   x_clk_i,
  input  wire                   y_clk_i,
  input  wire [`MAC8_OP_W-1:0]  x_data_i,
  input  wire [`MAC8_OP_W-1:0]  y_data_i,
  // mode controls
  input  wire                   accum_feedback_en_i,
  input  wire                   subtract_en_i,
  input  wire                   round_en_i,
  input  wire                   signed_format_sel_i,
  // product register strobe and preload
  input  wire                   p_clk_i,
  input  wire                   result_load_ext_i,
  input  wire                   ext_field_oe_n_i,
  input  wire                   high_field_oe_n_i,
  input  wire                   low_field_oe_n_i,
  // product pins, input side
  input  wire [2:0]             ext_field_i,
  input  wire [7:0]             high_field_i,
  input  wire [7:0]             low_field_i,
  // product pins, output side
  output wire [2:0]             ext_field_o,
  output wire [7:0]             high_field_o,
  output wire [7:0]             low_field_o,
  output wire                   ext_field_drv_n_o,
  output wire                   high_field_drv_n_o,
  output wire                   low_field_drv_n_o
);

  // synchroniser stages: s1 feeds s2 only
  reg  [2:0]  strb_s1_reg;
  reg  [2:0]  strb_s2_reg;
  reg  [2:0]  strb_s3_reg;
  reg         or_s3_reg;
  reg  [7:0]  x_s1_reg;
  reg  [7:0]  x_s2_reg;
  reg  [7:0]  y_s1_reg;
  reg  [7:0]  y_s2_reg;
  reg  [3:0]  mode_s1_reg;
  reg  [3:0]  mode_s2_reg;
  reg  [3:0]  tri_s1_reg;
  reg  [3:0]  tri_s2_reg;
  reg  [18:0] pin_s1_reg;
  reg  [18:0] pin_s2_reg;

  // datapath state
  reg  [7:0]  x_op_reg;
  reg  [7:0]  y_op_reg;
  reg         acc_mode_reg;
  reg         sub_mode_reg;
  reg         rnd_mode_reg;
  reg         tc_mode_reg;
  reg  [18:0] prod_reg;
  reg  [18:0] prod_next;

  wire        x_rise;
  wire        y_rise;
  wire        p_rise;
  wire        or_rise;
  wire [18:0] array_sum;
  wire [18:0] feedback;
  wire [18:0] new_prod;
  wire [15:0] full_prod;
  wire [18:0] addsub_res;
  wire [18:0] round_term;
  wire        take_ext;
  wire        take_high;
  wire        take_low;

  // data is delayed alongside its strobe so the two stay aligned
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strb_s1_reg <= 3'h0;
      strb_s2_reg <= 3'h0;
      strb_s3_reg <= 3'h0;
    end else begin
      strb_s1_reg <= {p_clk_i, y_clk_i, x_clk_i};
      strb_s2_reg <= strb_s1_reg;
      strb_s3_reg <= strb_s2_reg;
    end
  end

  // combined strobe history, so overlapping x and y give one capture
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      or_s3_reg <= 1'b0;
    end else begin
      or_s3_reg <= strb_s2_reg[0] | strb_s2_reg[1];
    end
  end

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      x_s1_reg <= `MAC8_OP_RST;
      x_s2_reg <= `MAC8_OP_RST;
    end else begin
      x_s1_reg <= x_data_i;
      x_s2_reg <= x_s1_reg;
    end
  end

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      y_s1_reg <= `MAC8_OP_RST;
      y_s2_reg <= `MAC8_OP_RST;
    end else begin
      y_s1_reg <= y_data_i;
      y_s2_reg <= y_s1_reg;
    end
  end

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_s1_reg <= 4'h0;
      mode_s2_reg <= 4'h0;
    end else begin
      mode_s1_reg <= {signed_format_sel_i, round_en_i, subtract_en_i, accum_feedback_en_i};
      mode_s2_reg <= mode_s1_reg;
    end
  end

  // reset level is float plus preload, so no port drives while in reset
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tri_s1_reg <= 4'hf;
      tri_s2_reg <= 4'hf;
    end else begin
      tri_s1_reg <= {result_load_ext_i, ext_field_oe_n_i, high_field_oe_n_i, low_field_oe_n_i};
      tri_s2_reg <= tri_s1_reg;
    end
  end

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_reg <= `MAC8_ACC_RST;
      pin_s2_reg <= `MAC8_ACC_RST;
    end else begin
      pin_s1_reg <= {ext_field_i, high_field_i, low_field_i};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // rising edge between the settled stage and the one after it
  function mac8_rise;
    input now_lvl;
    input was_lvl;
    begin
      mac8_rise = now_lvl & ~was_lvl;
    end
  endfunction

  // edge detectors look at settled stages only
  assign x_rise  = mac8_rise(strb_s2_reg[0], strb_s3_reg[0]);
  assign y_rise  = mac8_rise(strb_s2_reg[1], strb_s3_reg[1]);
  assign p_rise  = mac8_rise(strb_s2_reg[2], strb_s3_reg[2]);
  assign or_rise = mac8_rise(strb_s2_reg[0] | strb_s2_reg[1], or_s3_reg);

  // operand and mode registers
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      x_op_reg <= `MAC8_OP_RST;
    end else if (x_rise) begin
      x_op_reg <= x_s2_reg;
    end
  end

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      y_op_reg <= `MAC8_OP_RST;
    end else if (y_rise) begin
      y_op_reg <= y_s2_reg;
    end
  end

  // modes move only on the combined strobe, never in mid-product
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_mode_reg <= 1'b0;
      sub_mode_reg <= 1'b0;
      rnd_mode_reg <= 1'b0;
      tc_mode_reg  <= 1'b0;
    end else if (or_rise) begin
      acc_mode_reg <= mode_s2_reg[0];
      sub_mode_reg <= mode_s2_reg[1];
      rnd_mode_reg <= mode_s2_reg[2];
      tc_mode_reg  <= mode_s2_reg[3];
    end
  end

  // sign or zero extend one operand to 9 bits
  function [8:0] mac8_ext9;
    input [7:0] v;
    input       tc;
    begin
      mac8_ext9 = {tc & v[7], v};
    end
  endfunction

  // 9x9 signed product covers both formats; low 16 bits are exact
  wire signed [8:0]  x_ext;
  wire signed [8:0]  y_ext;
  wire signed [17:0] mul18;
  assign x_ext     = mac8_ext9(x_op_reg, tc_mode_reg);
  assign y_ext     = mac8_ext9(y_op_reg, tc_mode_reg);
  assign mul18     = x_ext * y_ext;
  assign full_prod = mul18[15:0];

  // widen to 19 bits by format
  assign new_prod  = {{3{tc_mode_reg & full_prod[15]}}, full_prod};
  // feedback gated off gives clear-on-first-product
  assign feedback  = acc_mode_reg ? prod_reg : `MAC8_ACC_RST;
  assign addsub_res = sub_mode_reg ? (new_prod - feedback) : (new_prod + feedback);
  assign round_term = rnd_mode_reg ? `MAC8_ROUND_VAL : `MAC8_ACC_RST;
  // 19-bit arithmetic wraps by truncation
  assign array_sum  = addsub_res + round_term;

  // a field takes its pins only when preload and its float control are both high
  function mac8_take;
    input preload;
    input oe_n;
    begin
      mac8_take = preload & oe_n;
    end
  endfunction

  assign take_ext  = mac8_take(tri_s2_reg[3], tri_s2_reg[2]);
  assign take_high = mac8_take(tri_s2_reg[3], tri_s2_reg[1]);
  assign take_low  = mac8_take(tri_s2_reg[3], tri_s2_reg[0]);

  // array is one combinational pass; well inside MAC8_CYCLE_CLKS
  always @* begin
    prod_next = array_sum;
    if (take_ext) begin
      prod_next[`MAC8_EXT_MSB:`MAC8_EXT_LSB] = pin_s2_reg[`MAC8_EXT_MSB:`MAC8_EXT_LSB];
    end
    if (take_high) begin
      prod_next[`MAC8_HIGH_MSB:`MAC8_HIGH_LSB] = pin_s2_reg[`MAC8_HIGH_MSB:`MAC8_HIGH_LSB];
    end
    if (take_low) begin
      prod_next[`MAC8_LOW_MSB:`MAC8_LOW_LSB] = pin_s2_reg[`MAC8_LOW_MSB:`MAC8_LOW_LSB];
    end
  end

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prod_reg <= `MAC8_ACC_RST;
    end else if (p_rise) begin
      prod_reg <= prod_next;
    end
  end

  // field outputs straight from the register
  assign ext_field_o  = prod_reg[`MAC8_EXT_MSB:`MAC8_EXT_LSB];
  assign high_field_o = prod_reg[`MAC8_HIGH_MSB:`MAC8_HIGH_LSB];
  assign low_field_o  = prod_reg[`MAC8_LOW_MSB:`MAC8_LOW_LSB];

  // a field drives only with its enable low and no preload pending
  function mac8_drv_n;
    input oe_n;
    input preload;
    begin
      mac8_drv_n = oe_n | preload;
    end
  endfunction

  // low means driving; preload forces all ports off
  assign ext_field_drv_n_o  = mac8_drv_n(tri_s2_reg[2], tri_s2_reg[3]);
  assign high_field_drv_n_o = mac8_drv_n(tri_s2_reg[1], tri_s2_reg[3]);
  assign low_field_drv_n_o  = mac8_drv_n(tri_s2_reg[0], tri_s2_reg[3]);

endmodule

`default_nettype wire

// *** mac8_defines.vh ***
// constants for the 8x8 multiply-accumulate datapath
// included by mac8_accumulator.v only
`ifndef MAC8_DEFINES_VH
`define MAC8_DEFINES_VH

// operand and result widths
`define MAC8_OP_W        8
`define MAC8_PROD_W      16
`define MAC8_ACC_W       19

// product register field positions
`define MAC8_LOW_LSB     0
`define MAC8_LOW_MSB     7
`define MAC8_HIGH_LSB    8
`define MAC8_HIGH_MSB    15
`define MAC8_EXT_LSB     16
`define MAC8_EXT_MSB     18

// rounding constant: one at the msb of the low field
`define MAC8_ROUND_VAL   19'h00080

// reset values
`define MAC8_ACC_RST     19'h00000
`define MAC8_OP_RST      8'h00

// timing
`define MAC8_CLK_NS      50
`define MAC8_CYCLE_NS    100
`define MAC8_CYCLE_CLKS  (`MAC8_CYCLE_NS / `MAC8_CLK_NS)

`endif

// *** mac8_host_pins.sv ***
// host side of the product pins: drives preload data on fields with en_i high while the block floats
// assumes drv_n low means the block drives that field
`timescale 1ns/1ps
`default_nettype none
module mac8_host_pins (
  // block side
  input  wire logic [18:0] dev_i,
  input  wire logic [2:0]  drv_n_i,
  // host side
  input  wire logic [2:0]  en_i,
  input  wire logic [18:0] val_i,
  // resolved pins
  output wire logic [18:0] pin_o
);
  // floating pins show the inverse, so a stale value never passes
  assign pin_o[18:16] = !drv_n_i[2] ? dev_i[18:16] : en_i[2] ? val_i[18:16] : ~dev_i[18:16];
  assign pin_o[15:8] = !drv_n_i[1] ? dev_i[15:8] : en_i[1] ? val_i[15:8] : ~dev_i[15:8];
  assign pin_o[7:0] = !drv_n_i[0] ? dev_i[7:0] : en_i[0] ? val_i[7:0] : ~dev_i[7:0];
endmodule
`default_nettype wire

// *** mac8_accumulator_sva.sv ***
// port checks for the multiply-accumulate block
// assumes two sync flops on every input of the block
`timescale 1ns/1ps
`default_nettype none
module mac8_accumulator_sva (
  // clock and reset
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  // watched inputs
  input wire logic       p_clk_i,
  input wire logic       result_load_ext_i,
  input wire logic       ext_field_oe_n_i,
  input wire logic       high_field_oe_n_i,
  input wire logic       low_field_oe_n_i,
  input wire logic [2:0] ext_field_i,
  input wire logic [7:0] high_field_i,
  input wire logic [7:0] low_field_i,
  // watched outputs
  input wire logic [2:0] ext_field_o,
  input wire logic [7:0] high_field_o,
  input wire logic [7:0] low_field_o,
  input wire logic       ext_field_drv_n_o,
  input wire logic       high_field_drv_n_o,
  input wire logic       low_field_drv_n_o
);
  logic [2:0] up_reg;
  logic [3:0] p_hist;
  wire        ok = up_reg == 3'h7;
  wire        pr = ok & p_hist[2] & ~p_hist[3];
  // $past is stale until seven edges after reset
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_reg <= 3'h0;
      p_hist <= 4'h0;
    end else begin
      up_reg <= ok ? up_reg : up_reg + 3'h1;
      p_hist <= {p_hist[2:0], p_clk_i};
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_ext_drive: assert property (ok |-> ext_field_drv_n_o ==
    ($past(ext_field_oe_n_i, 2) | $past(result_load_ext_i, 2))) else $error("ext drive wrong");
  chk_high_drive: assert property (ok |-> high_field_drv_n_o ==
    ($past(high_field_oe_n_i, 2) | $past(result_load_ext_i, 2))) else $error("high drive wrong");
  chk_low_drive: assert property (ok |-> low_field_drv_n_o ==
    ($past(low_field_oe_n_i, 2) | $past(result_load_ext_i, 2))) else $error("low drive wrong");
  chk_preload_float: assert property (ok && $past(result_load_ext_i, 2) |->
    ext_field_drv_n_o && high_field_drv_n_o && low_field_drv_n_o) else $error("driving in preload");
  chk_result_timing: assert property (ok && !$stable({ext_field_o, high_field_o, low_field_o}) |-> pr)
    else $error("result moved without strobe");
  chk_preload_ext: assert property (pr && $past(result_load_ext_i, 3) && $past(ext_field_oe_n_i, 3) |->
    ext_field_o == $past(ext_field_i, 3)) else $error("ext preload lost");
  chk_preload_high: assert property (pr && $past(result_load_ext_i, 3) && $past(high_field_oe_n_i, 3) |->
    high_field_o == $past(high_field_i, 3)) else $error("high preload lost");
  chk_preload_low: assert property (pr && $past(result_load_ext_i, 3) && $past(low_field_oe_n_i, 3) |->
    low_field_o == $past(low_field_i, 3)) else $error("low preload lost");
endmodule
bind mac8_accumulator mac8_accumulator_sva mac8_accumulator_sva_inst (.core_clk_i, .rst_n_i, .p_clk_i,
  .result_load_ext_i, .ext_field_oe_n_i, .high_field_oe_n_i, .low_field_oe_n_i, .ext_field_i, .high_field_i,
  .low_field_i, .ext_field_o, .high_field_o, .low_field_o,
  .ext_field_drv_n_o, .high_field_drv_n_o, .low_field_drv_n_o);
`default_nettype wire

// *** mac8_accumulator_tb.sv ***
// self-checking bench for the multiply-accumulate block
// assumes 20 MHz core clock; strobes held three cycles per phase
`timescale 1ns/1ps
`default_nettype none
module mac8_accumulator_tb;
  logic core_clk_i = 1'b0, rst_n_i, x_clk_i, y_clk_i, p_clk_i, result_load_ext_i;
  logic accum_feedback_en_i, subtract_en_i, round_en_i, signed_format_sel_i;
  logic ext_field_oe_n_i, high_field_oe_n_i, low_field_oe_n_i;
  logic ext_field_drv_n_o, high_field_drv_n_o, low_field_drv_n_o;
  logic [7:0] x_data_i, y_data_i, xm, ym;
  logic [3:0] mm;
  logic [18:0] host_val, model_acc, dev_w;
  wire [18:0] pin_w;
  wire [2:0] drv_w = {ext_field_drv_n_o, high_field_drv_n_o, low_field_drv_n_o};
  int n_fail = 0, comparisons = 0;
  always #25 core_clk_i = ~core_clk_i;
  mac8_accumulator mac8_accumulator_inst (.core_clk_i, .rst_n_i, .x_clk_i, .y_clk_i, .x_data_i, .y_data_i,
    .accum_feedback_en_i, .subtract_en_i, .round_en_i, .signed_format_sel_i, .p_clk_i, .result_load_ext_i,
    .ext_field_oe_n_i, .high_field_oe_n_i, .low_field_oe_n_i, .ext_field_i(pin_w[18:16]), .high_field_i(pin_w[15:8]),
    .low_field_i(pin_w[7:0]), .ext_field_o(dev_w[18:16]), .high_field_o(dev_w[15:8]), .low_field_o(dev_w[7:0]),
    .ext_field_drv_n_o, .high_field_drv_n_o, .low_field_drv_n_o);
  mac8_host_pins mac8_host_pins_inst (.dev_i(dev_w), .drv_n_i(drv_w),
    .en_i({3{result_load_ext_i}} & {ext_field_oe_n_i, high_field_oe_n_i, low_field_oe_n_i}),
    .val_i(host_val), .pin_o(pin_w));
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (n_fail == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // mm = {accumulate, subtract, round, signed}
  function automatic logic [18:0] mac_expect(input logic [18:0] fb);
    logic [18:0] pn;
    pn = mm[0] ? {{11{xm[7]}}, xm} * {{11{ym[7]}}, ym} : {11'h0, xm} * {11'h0, ym};
    fb = mm[3] ? fb : 19'h0;
    return (mm[2] ? pn - fb : pn + fb) + (mm[1] ? 19'h00080 : 19'h0);
  endfunction
  // po = {preload, ext/high/low oe_n}
  task automatic settle(input logic [3:0] po);
    logic [18:0] e, k;
    k = {{3{po[2]}}, {8{po[1]}}, {8{po[0]}}} & {19{po[3]}};
    e = (mac_expect(model_acc) & ~k) | (host_val & k);
    result_load_ext_i <= po[3];
    {ext_field_oe_n_i, high_field_oe_n_i, low_field_oe_n_i} <= po[2:0];
    cyc(3);
    p_clk_i <= 1'b1;
    cyc(3);
    p_clk_i <= 1'b0;
    cyc(3);
    model_acc = e;
    check(dev_w, e);
    check({16'h0, drv_w}, {16'h0, po[2:0] | {3{po[3]}}});
  endtask
  task automatic mac_op(input logic [1:0] w, input logic [7:0] x, y, input logic [3:0] m, po);
    xm = w[0] ? x : xm;
    ym = w[1] ? y : ym;
    mm = m;
    x_data_i <= x;
    y_data_i <= y;
    {accum_feedback_en_i, subtract_en_i, round_en_i, signed_format_sel_i} <= m;
    cyc(1);
    {y_clk_i, x_clk_i} <= w;
    cyc(3);
    {y_clk_i, x_clk_i} <= 2'b00;
    settle(po);
  endtask
  initial begin
    cyc(4000);
    n_fail++;
    complete_run();
  end
  initial begin
    {rst_n_i, x_clk_i, y_clk_i, p_clk_i, result_load_ext_i, x_data_i, y_data_i} = '0;
    {accum_feedback_en_i, subtract_en_i, round_en_i, signed_format_sel_i} = 4'h0;
    {ext_field_oe_n_i, high_field_oe_n_i, low_field_oe_n_i} = 3'h7;
    {host_val, model_acc, xm, ym} = '0;
    cyc(10);
    check(dev_w, 19'h0);
    check({16'h0, drv_w}, 19'h7);
    rst_n_i <= 1'b1;
    cyc(2);
    mac_op(2'b11, 8'h80, 8'h80, 4'b0001, 4'h0);
    mac_op(2'b11, 8'hff, 8'h02, 4'b0001, 4'h2);
    mac_op(2'b11, 8'hff, 8'h02, 4'b0000, 4'h5);
    mac_op(2'b11, 8'h10, 8'h10, 4'b1000, 4'h0);
    mac_op(2'b11, 8'h03, 8'h05, 4'b1100, 4'h0);
    mac_op(2'b11, 8'h03, 8'h05, 4'b0110, 4'h0);
    mac_op(2'b01, 8'h07, 8'h00, 4'b0000, 4'h0);
    mac_op(2'b10, 8'h00, 8'h09, 4'b0000, 4'h0);
    for (int i = 0; i < 9; i++)
      mac_op(2'b11, 8'hff, 8'hff, 4'b1000, 4'h0);
    host_val <= 19'h5a5a5;
    mac_op(2'b11, 8'h21, 8'h03, 4'b0000, 4'hd);
    mac_op(2'b11, 8'h01, 8'h01, 4'b1000, 4'ha);
    mac_op(2'b11, 8'h01, 8'h01, 4'b1000, 4'h0);
    // y rising while x is already high must not recapture the modes
    mac_op(2'b01, 8'h02, 8'h00, 4'b0000, 4'h0);
    x_clk_i <= 1'b1;
    cyc(3);
    // modes change only after the x rise has captured them
    y_data_i <= 8'h03;
    round_en_i <= 1'b1;
    cyc(3);
    y_clk_i <= 1'b1;
    cyc(3);
    {y_clk_i, x_clk_i} <= 2'b00;
    ym = 8'h03;
    settle(4'h0);
    // reset in mid-run clears the register and floats the ports
    rst_n_i <= 1'b0;
    cyc(2);
    check(dev_w, 19'h0);
    check({16'h0, drv_w}, 19'h7);
    rst_n_i <= 1'b1;
    model_acc = 19'h0;
    cyc(2);
    mac_op(2'b11, 8'h05, 8'h04, 4'b1000, 4'h0);
    complete_run();
  end
endmodule
`default_nettype wire
